// File: design/snfc_ctl.sv
// Serial NAND command decoder, feature registers and page buffer control.
`timescale 1ns/1ps
module snfc_ctl #(
  parameter int PAGE_BYTES = snfc_pkg::PAGE_BYTES_128,
  parameter int NUM_BLOCKS = snfc_pkg::NUM_BLOCKS_DEF,
  parameter int PROG_CYCLES = snfc_pkg::PROG_CYC
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Serial pins in
  input wire snfc_pkg::snfc_pins_t pins_in,
  // Serial pins out
  output snfc_pkg::snfc_pout_t pins_out
);
  import snfc_pkg::*;

  snfc_state_t r;
  snfc_state_t next_r;

  logic buf_we;
  logic [BUF_AW-1:0] buf_waddr;
  logic [7:0] buf_wdata;
  logic [BUF_AW-1:0] buf_raddr;
  logic [7:0] buf_rdata;

  logic rise;
  logic fall;
  logic [7:0] byte_in;
  logic [23:0] page_addr;
  logic [7:0] src;
  logic [7:0] wr_val;

  // ==========================================================================
  // Helpers
  function automatic logic is_locked(input logic [7:0] prot, input logic [23:0] page);
    logic [3:0] frac;
    int blk;
    int span;
    frac = prot[PR_FRAC_HI:PR_FRAC_LO];
    // Block index sits above the six page-in-block bits
    blk = int'(page[23:6]);
    span = 0;
    is_locked = 1'b0;
    if (frac == FRAC_ALL_A || frac == FRAC_ALL_B) begin
      is_locked = 1'b1;
    end else if (frac >= FRAC_MIN && frac <= FRAC_MAX) begin
      span = NUM_BLOCKS >> (FRAC_SHIFT_BASE - int'(frac));
      if (prot[PR_UPPER]) begin
        is_locked = (blk >= NUM_BLOCKS - span);
      end else begin
        is_locked = (blk < span);
      end
    end
  endfunction : is_locked

  function automatic logic [7:0] feature_byte(input snfc_state_t s);
    feature_byte = 8'h00;
    if (s.faddr == FA_PROTECT) begin
      feature_byte = s.protect & PROTECT_MASK;
    end else if (s.faddr == FA_CONFIG) begin
      feature_byte = s.cfg & CONFIG_MASK;
    end else if (s.faddr == FA_STATUS) begin
      feature_byte = {2'b00, s.correction_status, s.prog_fail, s.erase_fail,
                      s.write_latch, s.op_in_progress};
    end
  endfunction : feature_byte

  // Column pointer saturates so a runaway write stream cannot wrap onto byte 0; reads use only the low 12 bits
  function automatic logic [15:0] step_col(input logic [15:0] col);
    step_col = col;
    if (col != 16'hFFFF) begin
      step_col = col + 16'h0001;
    end
  endfunction : step_col

  // Range bits move only with the enable set and the write lock clear
  function automatic logic [7:0] protect_write(input logic [7:0] cur, input logic [7:0] d);
    protect_write = cur;
    protect_write[PR_CFG_PROT] = d[PR_CFG_PROT];
    if (cur[PR_CFG_PROT] && !cur[PR_WRITE_LOCK]) begin
      protect_write[7:2] = d[7:2];
    end
    protect_write = protect_write & PROTECT_MASK;
  endfunction : protect_write

  // A locked page or a fifth program to the same page both end in a fail flag
  function automatic logic prog_refused(input logic [7:0] prot, input logic [23:0] page,
                                        input logic [23:0] last, input logic [2:0] count);
    prog_refused = is_locked(prot, page);
    if (page == last && count >= MAX_PARTIAL) begin
      prog_refused = 1'b1;
    end
  endfunction : prog_refused

  // ==========================================================================
  // Page data register
  snfc_buf #(
    .DEPTH(PAGE_BYTES),
    .AW(BUF_AW)
  ) u_buf (
    .clk_sys(clk_sys),
    .we(buf_we),
    .waddr(buf_waddr),
    .wdata(buf_wdata),
    .raddr(buf_raddr),
    .rdata(buf_rdata)
  );

  // ==========================================================================
  // Next state
  always_comb begin
    next_r = r;
    // Pins cross in through two flops; only the second stage is looked at
    next_r.sync1 = pins_in;
    next_r.sync2 = r.sync1;
    next_r.sclk_q = r.sync2.sclk;
    rise = r.sync2.sclk & ~r.sclk_q & ~r.sync2.cs_n;
    fall = ~r.sync2.sclk & r.sclk_q & ~r.sync2.cs_n;
    byte_in = {r.shreg[6:0], r.sync2.si};
    page_addr = {r.addr[15:0], byte_in};
    buf_we = 1'b0;
    buf_waddr = r.col[BUF_AW-1:0];
    buf_wdata = byte_in;
    buf_raddr = r.col[BUF_AW-1:0];
    src = 8'h00;
    wr_val = 8'h00;

    // Array timer
    // Flag drops one cycle after the count reaches zero
    if (r.op_in_progress) begin
      if (r.busy_cnt == '0) begin
        next_r.op_in_progress = 1'b0;
      end else begin
        next_r.busy_cnt = r.busy_cnt - BUSY_W'(1);
      end
    end

    // Deselect drops any half-taken command
    if (r.sync2.cs_n) begin
      next_r.phase = SNFC_CMD;
      next_r.bit_cnt = 3'h0;
      next_r.byte_idx = 2'h0;
      next_r.pout.so_oe_n = 1'b1;
      next_r.pout.so = 1'b0;
    end else if (rise) begin
      next_r.shreg = byte_in;
      next_r.bit_cnt = r.bit_cnt + 3'h1;
      if (r.bit_cnt == 3'h7) begin
        case (r.phase)
          SNFC_CMD: begin
            next_r.cmd = byte_in;
            next_r.byte_idx = 2'h0;
            next_r.phase = SNFC_IGNORE;
            case (byte_in)
              CMD_WRITE_EN: begin
                if (!r.op_in_progress) begin
                  next_r.write_latch = 1'b1;
                end
              end
              CMD_WRITE_DIS: begin
                if (!r.op_in_progress) begin
                  next_r.write_latch = 1'b0;
                end
              end
              CMD_RESET: begin
                // Taken even while busy so a stuck array can be recovered
                next_r.cfg = r.cfg & ~CONFIG_SEL_MASK;
                next_r.op_in_progress = 1'b1;
                next_r.busy_cnt = BUSY_W'(RESET_CYC - 1);
              end
              CMD_GET_FEATURE: begin
                // Polling stays open during array work
                next_r.phase = SNFC_FADDR;
                next_r.get_mode = 1'b1;
              end
              CMD_SET_FEATURE: begin
                if (!r.op_in_progress) begin
                  next_r.phase = SNFC_FADDR;
                  next_r.get_mode = 1'b0;
                end
              end
              CMD_PAGE_READ, CMD_PROG_EXEC, CMD_PROG_LOAD, CMD_PROG_LOAD_RND,
              CMD_READ_BUF, CMD_READ_BUF_FAST: begin
                if (!r.op_in_progress) begin
                  next_r.phase = SNFC_ADDR;
                end
              end
              default: begin
                next_r.phase = SNFC_IGNORE;
              end
            endcase
          end
          SNFC_ADDR: begin
            // Array commands take three address bytes, column commands two
            next_r.addr = page_addr;
            next_r.byte_idx = r.byte_idx + 2'h1;
            if (r.cmd == CMD_PAGE_READ || r.cmd == CMD_PROG_EXEC) begin
              if (r.byte_idx == 2'h2) begin
                next_r.phase = SNFC_IGNORE;
                if (r.cmd == CMD_PAGE_READ) begin
                  // Array-to-register transfer time
                  next_r.op_in_progress = 1'b1;
                  next_r.busy_cnt = BUSY_W'(READ_CYC - 1);
                  next_r.correction_status = 2'b00;
                end else if (r.write_latch) begin
                  next_r.write_latch = 1'b0;
                  next_r.op_in_progress = 1'b1;
                  next_r.busy_cnt = BUSY_W'(PROG_CYCLES - 1);
                  if (prog_refused(r.protect, page_addr, r.last_page, r.partial_program_count)) begin
                    next_r.prog_fail = 1'b1;
                  end else begin
                    next_r.prog_fail = 1'b0;
                    next_r.last_page = page_addr;
                    if (page_addr == r.last_page) begin
                      next_r.partial_program_count = r.partial_program_count + 3'h1;
                    end else begin
                      next_r.partial_program_count = 3'h1;
                    end
                  end
                end
              end
            end else if (r.byte_idx == 2'h1) begin
              next_r.col = {r.addr[7:0], byte_in};
              if (r.cmd == CMD_PROG_LOAD || r.cmd == CMD_PROG_LOAD_RND) begin
                next_r.phase = SNFC_WDATA;
              end else begin
                next_r.phase = SNFC_DUMMY;
              end
            end
          end
          SNFC_DUMMY: begin
            next_r.phase = SNFC_RDATA;
          end
          SNFC_WDATA: begin
            // Overflow bytes are dropped, not wrapped
            if (int'(r.col) < PAGE_BYTES) begin
              buf_we = 1'b1;
            end
            next_r.col = step_col(r.col);
          end
          SNFC_FADDR: begin
            // Unknown addresses are kept too and simply read back as zero
            next_r.faddr = byte_in;
            next_r.phase = r.get_mode ? SNFC_FRDATA : SNFC_FWDATA;
          end
          SNFC_FWDATA: begin
            next_r.phase = SNFC_IGNORE;
            if (r.faddr == FA_PROTECT && r.sync2.wp_n && !r.cfg[CF_LOCKDOWN]) begin
              next_r.protect = protect_write(r.protect, byte_in);
            end else if (r.faddr == FA_CONFIG && r.sync2.wp_n) begin
              wr_val = byte_in & CONFIG_MASK;
              // Lock-down cannot be withdrawn short of power-on reset
              if (r.cfg[CF_LOCKDOWN]) begin
                wr_val[CF_LOCKDOWN] = 1'b1;
              end
              next_r.cfg = wr_val;
            end
          end
          default: begin
            next_r.phase = r.phase;
          end
        endcase
      end
    end else if (fall) begin
      if (r.phase == SNFC_RDATA || r.phase == SNFC_FRDATA) begin
        next_r.pout.so_oe_n = 1'b0;
        if (r.bit_cnt == 3'h0) begin
          // Same feature byte reloaded each byte until deselect
          src = (r.phase == SNFC_RDATA) ? buf_rdata : feature_byte(r);
          next_r.pout.so = src[7];
          next_r.out_shift = {src[6:0], 1'b0};
          if (r.phase == SNFC_RDATA) begin
            next_r.col = step_col(r.col);
          end
        end else begin
          next_r.pout.so = r.out_shift[7];
          next_r.out_shift = {r.out_shift[6:0], 1'b0};
        end
      end
    end

    // Reset sits last so it overrides every frame action above
    if (rst) begin
      next_r = '0;
      next_r.sync1.cs_n = 1'b1;
      next_r.sync2.cs_n = 1'b1;
      next_r.sync1.wp_n = 1'b1;
      next_r.sync2.wp_n = 1'b1;
      next_r.pout.so_oe_n = 1'b1;
      next_r.phase = SNFC_CMD;
      next_r.protect = PROTECT_RST;
      next_r.cfg = CONFIG_RST;
      next_r.last_page = 24'hFF_FFFF;
      buf_we = 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    r <= next_r;
  end

  assign pins_out = r.pout;

endmodule : snfc_ctl

// File: include/snfc_pkg.sv
// Shared constants and types for the serial NAND page and feature controller.
package snfc_pkg;

  // ==========================================================================
  // Commands
  localparam logic [7:0] CMD_WRITE_EN = 8'h06;
  localparam logic [7:0] CMD_WRITE_DIS = 8'h04;
  localparam logic [7:0] CMD_RESET = 8'hFF;
  localparam logic [7:0] CMD_GET_FEATURE = 8'h0F;
  localparam logic [7:0] CMD_SET_FEATURE = 8'h1F;
  localparam logic [7:0] CMD_PAGE_READ = 8'h13;
  localparam logic [7:0] CMD_PROG_EXEC = 8'h10;
  localparam logic [7:0] CMD_PROG_LOAD = 8'h02;
  localparam logic [7:0] CMD_PROG_LOAD_RND = 8'h84;
  localparam logic [7:0] CMD_READ_BUF = 8'h03;
  localparam logic [7:0] CMD_READ_BUF_FAST = 8'h0B;

  // ==========================================================================
  // Feature addresses
  localparam logic [7:0] FA_PROTECT = 8'hA0;
  localparam logic [7:0] FA_CONFIG = 8'hB0;
  localparam logic [7:0] FA_STATUS = 8'hC0;

  // ==========================================================================
  // Field positions
  localparam int PR_WRITE_LOCK = 7;
  localparam int PR_FRAC_HI = 6;
  localparam int PR_FRAC_LO = 3;
  localparam int PR_UPPER = 2;
  localparam int PR_CFG_PROT = 1;
  localparam int CF_LOCKDOWN = 5;
  localparam int CF_ECC_EN = 4;

  // ==========================================================================
  // Reset values and masks
  localparam logic [7:0] PROTECT_RST = 8'h7C;
  localparam logic [7:0] CONFIG_RST = 8'h10;
  localparam logic [7:0] PROTECT_MASK = 8'hFE;
  localparam logic [7:0] CONFIG_MASK = 8'hF2;
  localparam logic [7:0] CONFIG_SEL_MASK = 8'hC2;
  localparam logic [3:0] FRAC_ALL_A = 4'hB;
  localparam logic [3:0] FRAC_ALL_B = 4'hF;
  localparam logic [3:0] FRAC_MIN = 4'h1;
  localparam logic [3:0] FRAC_MAX = 4'h9;
  localparam int FRAC_SHIFT_BASE = 11;

  // ==========================================================================
  // Sizes
  localparam int PAGE_BYTES_128 = 2176;
  localparam int PAGE_BYTES_64 = 2112;
  localparam int NUM_BLOCKS_DEF = 2048;
  localparam logic [2:0] MAX_PARTIAL = 3'h4;
  localparam int BUF_AW = 12;
  localparam int BUSY_W = 16;

  // ==========================================================================
  // Timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int T_READ_NS = 45000;
  localparam int T_PROG_NS = 350000;
  localparam int T_RESET_NS = 2000;
  localparam int READ_CYC = ((T_READ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS) > 0 ?
                            ((T_READ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS) : 1;
  localparam int PROG_CYC = ((T_PROG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS) > 0 ?
                            ((T_PROG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS) : 1;
  localparam int RESET_CYC = ((T_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS) > 0 ?
                             ((T_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS) : 1;

  // ==========================================================================
  // Types
  typedef struct packed {
    logic sclk;
    logic cs_n;
    logic si;
    logic wp_n;
  } snfc_pins_t;

  typedef struct packed {
    logic so;
    logic so_oe_n;
  } snfc_pout_t;

  typedef enum logic [3:0] {
    SNFC_CMD = 4'b0000,
    SNFC_ADDR = 4'b0001,
    SNFC_DUMMY = 4'b0010,
    SNFC_RDATA = 4'b0011,
    SNFC_WDATA = 4'b0100,
    SNFC_FADDR = 4'b0101,
    SNFC_FWDATA = 4'b0110,
    SNFC_FRDATA = 4'b0111,
    SNFC_IGNORE = 4'b1000
  } snfc_phase_t;

  typedef struct packed {
    snfc_pins_t sync1;
    snfc_pins_t sync2;
    logic sclk_q;
    snfc_phase_t phase;
    logic [7:0] cmd;
    logic [2:0] bit_cnt;
    logic [1:0] byte_idx;
    logic [7:0] shreg;
    logic [23:0] addr;
    logic [15:0] col;
    logic [7:0] faddr;
    logic get_mode;
    logic [7:0] out_shift;
    snfc_pout_t pout;
    logic [7:0] protect;
    logic [7:0] cfg;
    logic write_latch;
    logic prog_fail;
    logic erase_fail;
    logic [1:0] correction_status;
    logic op_in_progress;
    logic [BUSY_W-1:0] busy_cnt;
    logic [2:0] partial_program_count;
    logic [23:0] last_page;
  } snfc_state_t;

endpackage : snfc_pkg

// File: design/snfc_buf.sv
// Page data register: byte-wide memory with registered read data.
`timescale 1ns/1ps
module snfc_buf #(
  parameter int DEPTH = 2176,
  parameter int AW = 12
) (
  // Clock
  input wire logic clk_sys,
  // Write side
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [7:0] wdata,
  // Read side
  input wire logic [AW-1:0] raddr,
  output logic [7:0] rdata
);

  typedef struct packed {
    logic [7:0] rdata;
  } snfc_buf_state_t;

  logic [7:0] mem [DEPTH];
  snfc_buf_state_t r;
  snfc_buf_state_t next_r;

  // ==========================================================================
  // Read path; addresses past the page read as erased
  always_comb begin
    next_r = r;
    if (int'(raddr) < DEPTH) begin
      next_r.rdata = mem[raddr];
    end else begin
      next_r.rdata = 8'hFF;
    end
  end

  always_ff @(posedge clk_sys) begin
    r <= next_r;
    if (we && int'(waddr) < DEPTH) begin
      mem[waddr] <= wdata;
    end
  end

  assign rdata = r.rdata;

endmodule : snfc_buf

// File: test/snfc_ctl_monitor.sv
// Port-level checker for the serial NAND command controller.
`timescale 1ns/1ps
module snfc_ctl_monitor (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Serial pins
  input wire snfc_pkg::snfc_pins_t pins_in,
  input wire snfc_pkg::snfc_pout_t pins_out
);
  import snfc_pkg::*;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  // ==========================================================================
  // Output enable framing
  a_start_quiet: assert property ($fell(rst) |-> (pins_out.so_oe_n && !pins_out.so) [*3])
    else $error("serial output active right after reset");
  a_idle_release: assert property (pins_in.cs_n [*5] |-> pins_out.so_oe_n)
    else $error("serial output driven while deselected");
  a_release_bound: assert property ($rose(pins_in.cs_n) |-> ##[1:5] pins_out.so_oe_n)
    else $error("serial output not released after deselect");
  a_drive_hold: assert property (!pins_out.so_oe_n && !pins_in.cs_n |=> !pins_out.so_oe_n)
    else $error("serial output dropped inside a read frame");
  a_oe_needs_select: assert property (!pins_out.so_oe_n |-> !$past(pins_in.cs_n, 6))
    else $error("serial output driven without a selected frame");
  a_enable_in_frame: assert property ($fell(pins_out.so_oe_n) |-> !pins_in.cs_n && !$past(pins_in.cs_n, 2))
    else $error("output enable fell outside a frame");

  // ==========================================================================
  // Shift timing: data moves only 2 to 5 samples after a falling serial clock
  a_shift_timing: assert property (
    !pins_out.so_oe_n && !$past(pins_out.so_oe_n) && !pins_in.cs_n && $changed(pins_out.so)
    |-> !$past(pins_in.sclk, 2) && ($past(pins_in.sclk, 3) || $past(pins_in.sclk, 4)
    || $past(pins_in.sclk, 5) || $past(pins_in.sclk, 6)))
    else $error("serial data changed off the falling clock");
  a_enable_timing: assert property (
    $fell(pins_out.so_oe_n) |-> !$past(pins_in.sclk, 2) && ($past(pins_in.sclk, 3)
    || $past(pins_in.sclk, 4) || $past(pins_in.sclk, 5) || $past(pins_in.sclk, 6)))
    else $error("output enable fell off the falling clock");
endmodule : snfc_ctl_monitor

bind snfc_ctl snfc_ctl_monitor mon_u (.clk_sys(clk_sys), .rst(rst), .pins_in(pins_in), .pins_out(pins_out));

// File: test/snfc_host_model.sv
// Behavioural SPI host that frames commands for the controller.
`timescale 1ns/1ps
module snfc_host_model (
  // Clock
  input wire logic clk_sys,
  // Link to the device
  output logic sclk,
  output logic cs_n,
  output logic si,
  input wire logic so
);
  logic [7:0] tx_q[$];
  logic [7:0] rx_q[$];

  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
  end

  // ==========================================================================
  // Frame engine
  // Mode 0 at 320 ns: 5 cycles low so the answer settles before the rise
  task automatic run(input int nrd);
    logic [7:0] b;
    rx_q.delete();
    @(negedge clk_sys);
    cs_n = 1'b0;
    for (int i = 0; i < tx_q.size() + nrd; i++) begin
      b = (i < tx_q.size()) ? tx_q[i] : 8'h00;
      for (int k = 7; k >= 0; k--) begin
        @(negedge clk_sys);
        sclk = 1'b0;
        si = b[k];
        repeat (5) @(negedge clk_sys);
        b[k] = so;
        sclk = 1'b1;
        repeat (2) @(negedge clk_sys);
      end
      if (i >= tx_q.size()) rx_q.push_back(b);
    end
    @(negedge clk_sys);
    sclk = 1'b0;
    repeat (2) @(negedge clk_sys);
    cs_n = 1'b1;
    repeat (4) @(negedge clk_sys);
  endtask : run
endmodule : snfc_host_model

// File: test/testbench.sv
// Self-checking bench for the serial NAND command controller.
`timescale 1ns/1ps
`define CHECK_EQ(nm, e, g) begin checks_done++; if ((g) !== (e)) begin fails++; \
  $display("Error %s expected %h seen %h", nm, e, g); end end
module testbench;
  import snfc_pkg::*;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic wp_n = 1'b1;
  logic h_sclk, h_cs_n, h_si;
  snfc_pins_t pins_in;
  snfc_pout_t pins_out;
  int fails = 0;
  int checks_done = 0;
  logic [7:0] v, prot_m;
  logic pfail = 1'b0;
  logic [7:0] modes [4] = '{8'h00, 8'h40, 8'hC0, 8'hC2};

  always #20 clk_sys = ~clk_sys;
  assign pins_in = {h_sclk, h_cs_n, h_si, wp_n};

  snfc_ctl #(.PROG_CYCLES(20)) dut_u (.clk_sys(clk_sys), .rst(rst), .pins_in(pins_in), .pins_out(pins_out));
  // Released line is seen inverted so a late or missing drive cannot pass
  snfc_host_model host_u (.clk_sys(clk_sys), .sclk(h_sclk), .cs_n(h_cs_n), .si(h_si),
                          .so(pins_out.so ^ pins_out.so_oe_n));

  // ==========================================================================
  // Expected protect register after a set-feature
  function automatic logic [7:0] next_prot(input logic [7:0] cur, input logic [7:0] d, input logic wp);
    next_prot = cur;
    if (wp) begin
      next_prot[PR_CFG_PROT] = d[PR_CFG_PROT];
      if (cur[PR_CFG_PROT] && !cur[PR_WRITE_LOCK]) next_prot[7:2] = d[7:2];
    end
  endfunction : next_prot

  // ==========================================================================
  // Link tasks
  task automatic xfer(input logic [63:0] w, input int nw, input int nrd);
    host_u.tx_q.delete();
    for (int i = nw - 1; i >= 0; i--) host_u.tx_q.push_back(w[i*8 +: 8]);
    host_u.run(nrd);
  endtask : xfer

  task automatic set_feat(input logic [7:0] fa, input logic [7:0] d);
    xfer({CMD_SET_FEATURE, fa, d}, 3, 0);
  endtask : set_feat

  task automatic get_chk(input logic [7:0] fa, input logic [7:0] e);
    xfer({CMD_GET_FEATURE, fa}, 2, 2);
    foreach (host_u.rx_q[i]) `CHECK_EQ("feature byte", e, host_u.rx_q[i])
  endtask : get_chk

  task automatic poll(output logic [7:0] first, output logic [7:0] st);
    int n;
    n = 0;
    do begin
      xfer({CMD_GET_FEATURE, FA_STATUS}, 2, 1);
      st = host_u.rx_q[0];
      if (n == 0) first = st;
      n++;
    end while (st[0] !== 1'b0 && n < 40);
    if (n >= 40) `CHECK_EQ("ready", 1'b0, st[0])
  endtask : poll

  task automatic prog(input logic [23:0] pa, input logic [7:0] d, input logic [7:0] e);
    logic [7:0] f, st;
    xfer(CMD_WRITE_EN, 1, 0);
    get_chk(FA_STATUS, {4'h0, pfail, 3'b010});
    xfer({CMD_PROG_LOAD, 16'h0000, d}, 4, 0);
    xfer({CMD_PROG_EXEC, pa}, 4, 0);
    poll(f, st);
    `CHECK_EQ("program status", e, st)
    pfail = e[3];
  endtask : prog

  task automatic reset_check;
    rst = 1'b1;
    repeat (3) @(negedge clk_sys);
    rst = 1'b0;
    pfail = 1'b0;
    repeat (3) @(negedge clk_sys);
    get_chk(FA_PROTECT, PROTECT_RST);
    get_chk(FA_CONFIG, CONFIG_RST);
    get_chk(FA_STATUS, 8'h00);
    get_chk(8'hD0, 8'h00);
  endtask : reset_check

  task automatic wrap_up;
    $display("Comparisons %0d, mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : wrap_up

  // ==========================================================================
  // Main sequence
  initial begin
    logic [7:0] f, st;
    v = $urandom(32'hc5e3_3512);
    reset_check();
    prog(24'h00_0040, v, 8'h08);
    prot_m = PROTECT_RST;
    for (int i = 0; i < 24; i++) begin
      v = $urandom;
      if (i < 20) v[PR_WRITE_LOCK] = 1'b0;
      wp_n = ($urandom % 4) != 0;
      set_feat(FA_PROTECT, v);
      prot_m = next_prot(prot_m, v, wp_n);
      get_chk(FA_PROTECT, prot_m);
    end
    wp_n = 1'b1;
    reset_check();
    set_feat(FA_PROTECT, 8'h02);
    set_feat(FA_PROTECT, 8'h02);
    get_chk(FA_PROTECT, 8'h02);
    // Smallest fraction at the bottom: blocks 0 and 1 locked, block 2 free
    set_feat(FA_PROTECT, 8'h0A);
    get_chk(FA_PROTECT, 8'h0A);
    prog(24'h00_0040, v, 8'h08);
    for (int i = 0; i < 5; i++) begin
      v = $urandom;
      prog(24'h00_0080, v, (i == 4) ? 8'h08 : 8'h00);
    end
    // Same fraction at the top: only the last two blocks locked
    set_feat(FA_PROTECT, 8'h0E);
    prog(24'h01_FFC0, v, 8'h08);
    set_feat(FA_PROTECT, 8'h02);
    xfer({CMD_READ_BUF, 24'h00_0000}, 4, 1);
    `CHECK_EQ("buffer col 0", v, host_u.rx_q[0])
    xfer({CMD_PROG_LOAD_RND, 16'(PAGE_BYTES_128 - 1), v, ~v}, 5, 0);
    xfer({CMD_PAGE_READ, 24'h00_0080}, 4, 0);
    poll(f, st);
    `CHECK_EQ("busy flag", 1'b1, f[0])
    `CHECK_EQ("read status", {4'h0, pfail, 3'b000}, st)
    xfer({CMD_READ_BUF_FAST, 16'(PAGE_BYTES_128 - 1), 8'h00}, 4, 1);
    `CHECK_EQ("buffer last col", v, host_u.rx_q[0])
    // Latch withdrawn, so the execute that follows must be ignored
    xfer(CMD_WRITE_EN, 1, 0);
    xfer(CMD_WRITE_DIS, 1, 0);
    xfer({CMD_PROG_EXEC, 24'h00_0100}, 4, 0);
    get_chk(FA_STATUS, {4'h0, pfail, 3'b000});
    foreach (modes[i]) begin
      set_feat(FA_CONFIG, modes[i] | 8'h10);
      get_chk(FA_CONFIG, modes[i] | 8'h10);
    end
    wp_n = 1'b0;
    set_feat(FA_CONFIG, 8'h10);
    get_chk(FA_CONFIG, 8'hD2);
    wp_n = 1'b1;
    xfer(CMD_RESET, 1, 0);
    poll(f, st);
    get_chk(FA_CONFIG, 8'h10);
    get_chk(FA_PROTECT, 8'h02);
    set_feat(FA_CONFIG, 8'h30);
    set_feat(FA_PROTECT, 8'h7E);
    get_chk(FA_PROTECT, 8'h02);
    set_feat(FA_CONFIG, 8'h10);
    get_chk(FA_CONFIG, 8'h30);
    wrap_up();
  end

  // Whole run is near 31k cycles; this cuts a hang well beyond it
  initial begin
    #3_000_000;
    fails++;
    wrap_up();
  end
endmodule : testbench
